// [low_power_mode_control.v]
// operating-mode controller: mode entry, wake, re-entry and clock/supply gating
`timescale 1ns/1ns
`include "lpm_ctrl_defs.vh"
module low_power_mode_control (
    // clock and reset
    input wire i_core_clk,
    input wire i_rst,
    // software mode request from the processor
    input wire i_mode_req,
    input wire [2:0] i_mode_sel,
    input wire i_irq_return,
    // wake sources
    input wire i_irq_event,
    input wire i_io_wake,
    input wire i_counter_wake,
    // low-frequency clock requests and external clock flags
    input wire i_lf_periph_req,
    input wire i_crystal_lowfreq_external,
    // status
    output reg [2:0] o_mode,
    output reg o_servicing,
    // gating
    output reg o_main_clk_en,
    output reg o_subsystem_clock_en,
    output reg o_digital_controlled_osc_en,
    output reg o_frequency_locked_loop_en,
    output reg o_crystal_lowfreq_clock_en,
    output reg o_very_low_freq_clock_en,
    output reg o_core_supply_en,
    output reg o_io_hold
);
    // =========================================
    // states
    localparam [3:0] ST_ACTIVE = 4'h1;
    localparam [3:0] ST_LOW = 4'h2;
    localparam [3:0] ST_WAKE = 4'h4;
    localparam [3:0] ST_SERVICE = 4'h8;

    reg [3:0] state_reg;
    reg [3:0] state_next;
    reg [2:0] mode_reg;
    reg [2:0] mode_next;
    reg [2:0] saved_reg;
    reg [2:0] saved_next;
    reg [`WAKE_CNT_W-1:0] cnt_reg;
    reg [`WAKE_CNT_W-1:0] cnt_next;

    // shutdown modes lose the core; only a reset brings them back in silicon
    function is_shutdown(input [2:0] m);
        is_shutdown = (m == `MODE_COUNTER_ONLY) || (m == `MODE_FULL_SHUTDOWN);
    endfunction

    // =========================================
    // wake sources allowed per mode
    reg wake_hit;
    always @* begin
        wake_hit = i_io_wake;
        case (mode_reg)
            `MODE_CPU_OFF: begin
                wake_hit = i_irq_event | i_io_wake | i_counter_wake;
            end
            `MODE_STANDBY: begin
                wake_hit = i_irq_event | i_io_wake | i_counter_wake;
            end
            `MODE_COUNTER_ONLY: begin
                wake_hit = i_io_wake | i_counter_wake;
            end
            default: begin
                // off, full shutdown and unlisted codes: pins only
                wake_hit = i_io_wake;
            end
        endcase
    end

    // =========================================
    // next state
    always @* begin
        state_next = state_reg;
        mode_next = mode_reg;
        saved_next = saved_reg;
        cnt_next = cnt_reg;
        case (state_reg)
            ST_ACTIVE: begin
                if (i_mode_req && i_mode_sel != `MODE_ACTIVE) begin
                    mode_next = i_mode_sel;
                    saved_next = i_mode_sel;
                    state_next = ST_LOW;
                end
            end
            ST_LOW: begin
                if (wake_hit) begin
                    // cpu-off loads a zero count and goes active one cycle later; others wait for the oscillator
                    cnt_next = (mode_reg == `MODE_CPU_OFF) ? {`WAKE_CNT_W{1'b0}} :
                               `WAKE_LOAD;
                    state_next = ST_WAKE;
                end
            end
            ST_WAKE: begin
                if (cnt_reg == {`WAKE_CNT_W{1'b0}}) begin
                    mode_next = `MODE_ACTIVE;
                    // shutdown exits behave as a fresh start, no re-entry
                    state_next = is_shutdown(saved_reg) ? ST_ACTIVE : ST_SERVICE;
                end else begin
                    cnt_next = cnt_reg - 1'b1;
                end
            end
            ST_SERVICE: begin
                if (i_irq_return) begin
                    mode_next = saved_reg;
                    state_next = ST_LOW;
                end else if (i_mode_req) begin
                    saved_next = i_mode_sel;
                    if (i_mode_sel == `MODE_ACTIVE)
                        state_next = ST_ACTIVE;
                end
            end
            default: begin
                state_next = ST_ACTIVE;
                mode_next = `MODE_ACTIVE;
            end
        endcase
    end

    always @(posedge i_core_clk or posedge i_rst) begin
        if (i_rst) begin
            state_reg <= ST_ACTIVE;
            mode_reg <= `MODE_ACTIVE;
            saved_reg <= `MODE_ACTIVE;
            cnt_reg <= {`WAKE_CNT_W{1'b0}};
        end else begin
            state_reg <= state_next;
            mode_reg <= mode_next;
            saved_reg <= saved_next;
            cnt_reg <= cnt_next;
        end
    end

    // =========================================
    // per-mode gating table, taken from the mode about to be entered
    reg main_clk_next;
    reg subsystem_clock_next;
    reg osc_next;
    reg fll_next;
    reg crystal_next;
    reg vlo_next;
    reg supply_next;
    reg io_hold_next;
    always @* begin
        main_clk_next = 1'b0;
        subsystem_clock_next = 1'b0;
        osc_next = 1'b0;
        fll_next = 1'b0;
        crystal_next = 1'b0;
        vlo_next = 1'b0;
        supply_next = 1'b1;
        io_hold_next = 1'b1;
        case (mode_next)
            `MODE_ACTIVE: begin
                main_clk_next = 1'b1;
                subsystem_clock_next = 1'b1;
                osc_next = 1'b1;
                fll_next = 1'b1;
                crystal_next = 1'b1;
                vlo_next = 1'b1;
                io_hold_next = 1'b0;
            end
            `MODE_CPU_OFF: begin
                subsystem_clock_next = 1'b1;
                osc_next = 1'b1;
                fll_next = 1'b1;
                crystal_next = 1'b1;
                vlo_next = 1'b1;
                io_hold_next = 1'b0;
            end
            `MODE_OFF: begin
                // an external crystal source is not stopped by the gate
                crystal_next = i_lf_periph_req | i_crystal_lowfreq_external;
                vlo_next = i_lf_periph_req;
            end
            `MODE_COUNTER_ONLY: begin
                crystal_next = 1'b1;
                vlo_next = 1'b1;
                supply_next = 1'b0;
            end
            `MODE_FULL_SHUTDOWN: begin
                supply_next = 1'b0;
            end
            default: begin
                // standby and unlisted codes keep the low-freq pair
                crystal_next = 1'b1;
                vlo_next = 1'b1;
            end
        endcase
        // oscillator restarts during the wake delay
        if (state_next == ST_WAKE)
            osc_next = 1'b1;
    end

    // =========================================
    // registered gating outputs
    always @(posedge i_core_clk or posedge i_rst) begin
        if (i_rst) begin
            o_mode <= `MODE_ACTIVE;
            o_servicing <= 1'b0;
            o_main_clk_en <= 1'b1;
            o_subsystem_clock_en <= 1'b1;
            o_digital_controlled_osc_en <= 1'b1;
            o_frequency_locked_loop_en <= 1'b1;
            o_crystal_lowfreq_clock_en <= 1'b1;
            o_very_low_freq_clock_en <= 1'b1;
            o_core_supply_en <= 1'b1;
            o_io_hold <= 1'b0;
        end else begin
            o_mode <= mode_next;
            o_servicing <= (state_next == ST_SERVICE);
            o_main_clk_en <= main_clk_next;
            o_subsystem_clock_en <= subsystem_clock_next;
            o_digital_controlled_osc_en <= osc_next;
            o_frequency_locked_loop_en <= fll_next;
            o_crystal_lowfreq_clock_en <= crystal_next;
            o_very_low_freq_clock_en <= vlo_next;
            o_core_supply_en <= supply_next;
            o_io_hold <= io_hold_next;
        end
    end
endmodule // low_power_mode_control

// [lpm_ctrl_defs.vh]
// constants for the low-power mode controller
// Summary of operation
// - one active mode plus software-selectable low-power modes, chosen at run time
// - interrupts wake cpu-off and standby modes; return re-enters same mode
// - counter-only and full shutdown modes remove the core supply
// - oscillator wake from low-power to active within about 10 us
// - in off mode low-freq clocks run only while a peripheral requests them
// - off-mode clock stop applies to internal clocks only, not external ones
`ifndef LPM_CTRL_DEFS_VH
`define LPM_CTRL_DEFS_VH
// =========================================
// mode select codes
`define MODE_ACTIVE 3'h0
`define MODE_CPU_OFF 3'h1
`define MODE_STANDBY 3'h3
`define MODE_OFF 3'h4
`define MODE_COUNTER_ONLY 3'h5
`define MODE_FULL_SHUTDOWN 3'h6
// =========================================
// timing
`define CLK_PERIOD_NS 50
`define WAKE_TIME_NS 10000
`define WAKE_CYCLES (`WAKE_TIME_NS / `CLK_PERIOD_NS)
`define WAKE_CNT_W 8
// counter load value, WAKE_CYCLES - 1, sized to the counter width
`define WAKE_LOAD 8'hc7
`endif

// [lpm_asserts.sv]
// checker for the low-power mode controller
`timescale 1ns/1ns
module lpm_asserts (
    // clock, reset and requests
    input i_core_clk, i_rst, i_mode_req, i_irq_return, i_irq_event,
    input [2:0] i_mode_sel,
    input i_lf_periph_req, i_crystal_lowfreq_external,
    // status and gating
    input [2:0] o_mode,
    input o_servicing, o_main_clk_en, o_subsystem_clock_en, o_frequency_locked_loop_en,
    input o_io_hold, o_core_supply_en, o_very_low_freq_clock_en, o_crystal_lowfreq_clock_en
);
// =========================================
// checks
default clocking @(posedge i_core_clk); endclocking
default disable iff (i_rst);
wire take = i_mode_req && o_mode == 3'h0 && !o_servicing;
chk_mode_taken: assert property (take && i_mode_sel inside {3'h1, 3'h3, 3'h4}
    |=> o_mode == $past(i_mode_sel) && !o_main_clk_en) else $error("mode");
chk_return_reenter: assert property (o_servicing && i_irq_return && !i_mode_req
    |=> o_mode != 3'h0 && !o_servicing) else $error("reenter");
chk_supply_off: assert property (take && i_mode_sel inside {3'h5, 3'h6}
    |=> !o_core_supply_en) else $error("supply");
chk_wake_time: assert property (o_mode == 3'h3 && i_irq_event
    |-> ##[1:202] o_mode == 3'h0) else $error("wake late");
chk_off_vlo: assert property (o_mode == 3'h4 ##1 o_mode == 3'h4
    |-> o_very_low_freq_clock_en == $past(i_lf_periph_req)) else $error("vlo");
chk_off_crystal: assert property (o_mode == 3'h4 ##1 o_mode == 3'h4 |-> o_crystal_lowfreq_clock_en
    == ($past(i_lf_periph_req) || $past(i_crystal_lowfreq_external))) else $error("xt");
chk_deep_gated: assert property (take && i_mode_sel == 3'h3 |=> !o_subsystem_clock_en
    && !o_frequency_locked_loop_en && o_io_hold) else $error("deep");
cover property (o_mode == 3'h3);
cover property ($rose(o_servicing));
cover property (o_mode == 3'h4 && i_lf_periph_req);
endmodule // lpm_asserts
bind low_power_mode_control lpm_asserts u_chk (.*);

// [tb_top.sv]
// self-checking bench for the low-power mode controller
`timescale 1ns/1ns
module tb_top;
logic i_core_clk = 0, i_rst = 1, i_mode_req = 0, i_irq_return = 0, i_irq_event = 0;
logic i_io_wake = 0, i_counter_wake = 0, i_lf_periph_req = 0, i_crystal_lowfreq_external = 0;
logic [2:0] i_mode_sel = 0, o_mode;
logic o_servicing, o_main_clk_en, o_subsystem_clock_en, o_digital_controlled_osc_en, o_io_hold;
logic o_frequency_locked_loop_en, o_crystal_lowfreq_clock_en, o_very_low_freq_clock_en;
logic o_core_supply_en;
int err_count = 0, compares = 0;
always #25 i_core_clk = ~i_core_clk;
low_power_mode_control DUT (.*);
// =========================================
// shared tasks
task test_done;
    if (err_count == 0 && compares > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
endtask
task chk(input string n, input logic [7:0] s, e);
    compares++;
    if (s !== e) begin
        err_count++;
        $display("mismatch %s exp %h seen %h", n, e, s);
    end
endtask
task go(input logic [2:0] s);
    @(posedge i_core_clk) i_mode_req <= 1;
    i_mode_sel <= s;
    @(posedge i_core_clk) i_mode_req <= 0;
    #1;
endtask
// bounded wait: a stuck wake ends the run
task wake(input int w, lim, input logic sv);
    int n;
    n = 0;
    @(posedge i_core_clk);
    case (w)
        0: i_irq_event <= 1;
        1: i_io_wake <= 1;
        default: i_counter_wake <= 1;
    endcase
    @(posedge i_core_clk) {i_irq_event, i_io_wake, i_counter_wake} <= 3'h0;
    #1 chk("osc_wake", o_digital_controlled_osc_en, 1);
    while (o_mode !== 3'h0 && n < lim) begin
        @(posedge i_core_clk);
        #1 n++;
    end
    chk("wake_mode", o_mode, 0);
    chk("serving", o_servicing, sv);
    chk("all_on", {o_main_clk_en, o_digital_controlled_osc_en, o_core_supply_en}, 3'h7);
    if (o_mode !== 3'h0) test_done;
endtask
// =========================================
// scenarios
task t_low(input logic [2:0] s, input int w, lim);
    go(s);
    chk("mode", o_mode, s);
    chk("main", o_main_clk_en, 0);
    if (s != 3'h1) chk("deep", {o_subsystem_clock_en, o_frequency_locked_loop_en, o_io_hold}, 1);
    for (int k = 0; k < 4 && s == 3'h4; k++) begin
        @(posedge i_core_clk) {i_lf_periph_req, i_crystal_lowfreq_external} <= k[1:0];
        @(posedge i_core_clk);
        #1 chk("vlo", o_very_low_freq_clock_en, k[1]);
        chk("xtal", o_crystal_lowfreq_clock_en, k[1] | k[0]);
    end
    wake(w, lim, 1);
    @(posedge i_core_clk) i_irq_return <= 1;
    @(posedge i_core_clk) i_irq_return <= 0;
    #1 chk("reenter", o_mode, s);
    wake(w, lim, 1);
    go(0);
    chk("active", {o_mode, o_servicing}, 0);
endtask
task t_shut(input logic [2:0] s, input int w);
    go(s);
    chk("supply", {o_mode, o_core_supply_en}, {s, 1'b0});
    wake(w, 201, 0);
endtask
// mid-run reset from standby: everything back on, pins released
task t_reset;
    go(3);
    @(posedge i_core_clk) i_rst <= 1;
    @(posedge i_core_clk);
    #1 chk("rst_state", {o_mode, o_servicing, o_io_hold}, 0);
    chk("rst_gates", {o_main_clk_en, o_subsystem_clock_en, o_digital_controlled_osc_en,
        o_frequency_locked_loop_en, o_crystal_lowfreq_clock_en, o_very_low_freq_clock_en,
        o_core_supply_en}, 8'h7f);
    @(posedge i_core_clk) i_rst <= 0;
    @(posedge i_core_clk);
    #1 chk("post_rst", o_mode, 0);
endtask
initial begin
    repeat (20) @(posedge i_core_clk);
    i_rst <= 0;
    t_low(1, 0, 2);
    t_low(3, 0, 201);
    t_low(4, 1, 201);
    t_reset;
    t_shut(5, 2);
    t_shut(6, 1);
    test_done;
end
endmodule // tb_top
